//--- logic/dcg_pkg.sv
/*
 * Constants, types and register map of the DSP module clock gate sequencer.
 * Assumes a single 10 MHz always-on controller clock and a plain register port.
 */
// Overview of operation
// - A started disable transition raises the power-down interrupt to the DSP.
// - Pending bit 1 stays set until clock stopping completes after the DSP executes idle.
// - Status state field reads 2h once clock stopping completes.
// - In Disable the root clock is stopped at the PLL output.
// - Power-down command register accepts writes only in supervisor mode.
// - On full shutdown the memory controllers, CPU and memories get gated.
// - Idle alone puts only the CPU into low power, without a transition.
// - After reset the module is in Enable with its clock running.
// - Enable completion changes the status state field to 3h.
package dcg_pkg;
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam logic [3:0]  OFS_MOD_CTL     = 4'h0;
	localparam logic [3:0]  OFS_MOD_STAT    = 4'h4;
	localparam logic [3:0]  OFS_DOM_CMD     = 4'h8;
	localparam logic [3:0]  OFS_DOM_STAT    = 4'hC;
	localparam logic [1:0]  ST_DISABLE      = 2'h2;
	localparam logic [1:0]  ST_ENABLE       = 2'h3;
	localparam int          GO_BIT          = 1;
	localparam logic [31:0] PDC_SLEEP_KEY   = 32'h00015555;
	localparam int          GATE_W          = 8;
	localparam logic [7:0]  GATE_ALL        = 8'hFF;
	localparam logic [7:0]  GATE_NONE       = 8'h00;
	localparam int          CLK_NS          = 100;
	localparam int          SETTLE_NS       = 300;
	localparam int          SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		DCG_RUN     = 2'b00,
		DCG_WAIT_ID = 2'b01,
		DCG_SETTLE  = 2'b10,
		DCG_OFF     = 2'b11
	} dcg_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} dcg_bus_t;
endpackage : dcg_pkg

//--- logic/dcg_sequencer.sv
/*
 * DSP module clock gate sequencer: module control/status, domain go and pending,
 * power-down interrupt, command register and root clock gate.
 * Assumes DSP-side inputs arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ns
module dcg_sequencer
	import dcg_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYC
) (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire dcg_bus_t          bus,
	output logic [DATA_W-1:0]      rdata,
	input  wire logic              dsp_idle,
	input  wire logic              dsp_supervisor,
	input  wire logic              dsp_cmd_wr,
	input  wire logic [DATA_W-1:0] dsp_cmd_data,
	output logic                   powerdown_interrupt,
	output logic                   processor_root_clock_en,
	output logic                   cpu_lowpower,
	output logic [GATE_W-1:0]      mem_gate
);
	initial begin
		if (SETTLE < 1) $error("SETTLE must be at least one cycle.");
		// The settle counter is eight bits wide, so longer settle times cannot be served.
		if (SETTLE > 255) $error("SETTLE must fit the eight bit settle counter.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for signals from the DSP core.
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [DATA_W-1:0] cd1_reg;
	logic [DATA_W-1:0] cd2_reg;
	logic       idle_s;
	logic       sup_s;
	logic       cwr_s;
	logic       cwr_d_reg;
	always_ff @(posedge mclk) begin
		s1_reg    <= {dsp_cmd_wr, dsp_supervisor, dsp_idle};
		s2_reg    <= s1_reg;
		cd1_reg   <= dsp_cmd_data;
		cd2_reg   <= cd1_reg;
		cwr_d_reg <= srst ? 1'b0 : s2_reg[2];
	end
	assign idle_s = s2_reg[0];
	assign sup_s  = s2_reg[1];
	assign cwr_s  = s2_reg[2] & ~cwr_d_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state.
	dcg_state_t        st_reg,      st_next;
	logic [1:0]        nxt_reg,     nxt_next;
	logic [1:0]        mstat_reg,   mstat_next;
	logic              pend_reg,    pend_next;
	logic              pint_reg,    pint_next;
	logic [DATA_W-1:0] pdcmd_reg,   pdcmd_next;
	logic [7:0]        cnt_reg,     cnt_next;
	logic [DATA_W-1:0] rdata_reg,   rdata_next;
	logic              armed;
	logic              go;

	assign go    = bus.wr && bus.addr == OFS_DOM_CMD && bus.wdata[GO_BIT] && !pend_reg;
	assign armed = pdcmd_reg == PDC_SLEEP_KEY;

	always_comb begin
		st_next    = st_reg;
		nxt_next   = nxt_reg;
		mstat_next = mstat_reg;
		pend_next  = pend_reg;
		pint_next  = pint_reg;
		pdcmd_next = pdcmd_reg;
		cnt_next   = cnt_reg;
		rdata_next = '0;
		if (bus.wr && bus.addr == OFS_MOD_CTL) begin
			nxt_next = bus.wdata[1:0];
		end
		if (cwr_s && sup_s) begin
			pdcmd_next = cd2_reg;
		end
		case (st_reg)
			DCG_RUN: begin
				if (go && nxt_reg == ST_DISABLE && mstat_reg != ST_DISABLE) begin
					pend_next = 1'b1;
					pint_next = 1'b1;
					st_next   = DCG_WAIT_ID;
				end
			end
			DCG_WAIT_ID: begin
				if (idle_s) begin
					pint_next = 1'b0;
					st_next   = DCG_SETTLE;
					cnt_next  = 8'(SETTLE);
				end
			end
			DCG_SETTLE: begin
				if (cnt_reg <= 8'h01) begin
					pend_next  = 1'b0;
					mstat_next = ST_DISABLE;
					st_next    = DCG_OFF;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			DCG_OFF: begin
				if (go && nxt_reg == ST_ENABLE) begin
					pend_next  = 1'b0;
					mstat_next = ST_ENABLE;
					pdcmd_next = '0;
					st_next    = DCG_RUN;
				end
			end
			default: st_next = DCG_RUN;
		endcase
		if (bus.rd) begin
			case (bus.addr)
				OFS_MOD_CTL:  rdata_next = {30'h0, nxt_reg};
				OFS_MOD_STAT: rdata_next = {30'h0, mstat_reg};
				OFS_DOM_STAT: rdata_next = {30'h0, pend_reg, 1'b0};
				default:      rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg    <= DCG_RUN;
			nxt_reg   <= ST_ENABLE;
			mstat_reg <= ST_ENABLE;
			pend_reg  <= 1'b0;
			pint_reg  <= 1'b0;
			pdcmd_reg <= '0;
			cnt_reg   <= 8'h00;
			rdata_reg <= '0;
		end else begin
			st_reg    <= st_next;
			nxt_reg   <= nxt_next;
			mstat_reg <= mstat_next;
			pend_reg  <= pend_next;
			pint_reg  <= pint_next;
			pdcmd_reg <= pdcmd_next;
			cnt_reg   <= cnt_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs. The root clock is held off only in the Disable state so the tree idles.
	logic [GATE_W-1:0] gate_reg;
	logic              clk_en_reg;
	logic              lp_reg;
	always_ff @(posedge mclk) begin
		if (srst) begin
			gate_reg   <= GATE_NONE;
			clk_en_reg <= 1'b1;
			lp_reg     <= 1'b0;
		end else begin
			gate_reg   <= (idle_s && armed) ? GATE_ALL : GATE_NONE;
			clk_en_reg <= st_next != DCG_OFF;
			lp_reg     <= idle_s;
		end
	end
	assign rdata                   = rdata_reg;
	assign powerdown_interrupt     = pint_reg;
	assign processor_root_clock_en = clk_en_reg;
	assign cpu_lowpower            = lp_reg;
	assign mem_gate                = gate_reg;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_go_disable;
		go && nxt_reg == ST_DISABLE && st_reg == DCG_RUN && mstat_reg != ST_DISABLE;
	endsequence

	AST_PINT_ON_GO: assert property (s_go_disable |=> powerdown_interrupt && pend_reg)
		else $error("Power-down interrupt not raised on disable go.");
	AST_PEND_HOLD: assert property (st_reg == DCG_WAIT_ID |-> pend_reg)
		else $error("Pending cleared before idle.");
	AST_STAT_DIS: assert property ($fell(pend_reg) && st_reg == DCG_OFF |-> mstat_reg == ST_DISABLE)
		else $error("Status not Disable at completion.");
	AST_ROOT_OFF: assert property (st_reg == DCG_OFF |-> !processor_root_clock_en)
		else $error("Root clock running in Disable.");
	AST_SUP_ONLY: assert property (cwr_s && !sup_s |=> $stable(pdcmd_reg))
		else $error("Command register written outside supervisor mode.");
	AST_STAT_EN: assert property (st_reg == DCG_OFF && go && nxt_reg == ST_ENABLE |=> mstat_reg == ST_ENABLE)
		else $error("Status not Enable after enable transition.");
	// The disable sequence may still advance on idle, so only a fall back to Run is an error.
	AST_NO_GO: assert property (bus.wr && bus.addr == OFS_DOM_CMD && pend_reg |=> st_reg != DCG_RUN)
		else $error("Go while pending disturbed the sequence.");
	AST_SETTLE: assert property (st_reg == DCG_WAIT_ID && idle_s |=> ##[1:256] st_reg == DCG_OFF)
		else $error("Disable did not complete after idle.");

	sequence s_idle_in_wait;
		st_reg == DCG_WAIT_ID && idle_s;
	endsequence

	sequence s_off_no_enable;
		st_reg == DCG_OFF && !(go && nxt_reg == ST_ENABLE);
	endsequence

	AST_PINT_DROP: assert property (s_idle_in_wait |=> !powerdown_interrupt)
		else $error("Power-down interrupt still high after idle.");
	AST_PINT_QUIET: assert property (st_reg == DCG_RUN || st_reg == DCG_OFF |-> !powerdown_interrupt)
		else $error("Power-down interrupt high outside a disable transition.");
	AST_PEND_DONE: assert property (st_reg == DCG_OFF |-> !pend_reg)
		else $error("Pending still set in Disable.");
	AST_ROOT_ON: assert property (st_reg != DCG_OFF |-> processor_root_clock_en)
		else $error("Root clock stopped outside Disable.");
	AST_GATE_KEY: assert property (!armed |=> mem_gate == GATE_NONE)
		else $error("Memories gated without the command key.");
	AST_LP_ON: assert property (idle_s |=> cpu_lowpower)
		else $error("CPU not in low power during idle.");
	AST_LP_OFF: assert property (!idle_s |=> !cpu_lowpower)
		else $error("CPU in low power without idle.");
	AST_OFF_HOLD: assert property (s_off_no_enable |=> st_reg == DCG_OFF)
		else $error("Disable left without an enable go.");
	AST_RUN_HOLD: assert property (st_reg == DCG_RUN && !go |=> st_reg == DCG_RUN)
		else $error("Transition started without a go.");
	AST_RDATA_ZERO: assert property (!bus.rd |=> rdata == '0)
		else $error("Read data not zero outside a read answer.");
endmodule : dcg_sequencer

//--- testbench/dcg_dsp_model.sv
/* DSP partner: answers the power-down interrupt with a key write and idle.
   Assumes the bench raises wake to end idle. */
`timescale 1ns/1ns
module dcg_dsp_model
	import dcg_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              powerdown_interrupt,
	input  wire logic              wake,
	output logic                   dsp_idle,
	output logic                   dsp_supervisor,
	output logic                   dsp_cmd_wr,
	output logic [DATA_W-1:0]      dsp_cmd_data
);
	initial begin
		dsp_idle = 1'b0;
		dsp_supervisor = 1'b0;
		dsp_cmd_wr = 1'b0;
		dsp_cmd_data = ~PDC_SLEEP_KEY;
		forever begin
			@(posedge mclk);
			if (powerdown_interrupt === 1'b1 && !dsp_idle) begin
				repeat (4) @(posedge mclk);
				dsp_cmd_data <= PDC_SLEEP_KEY;
				repeat (3) @(posedge mclk);
				// A user-mode write first, which the block must refuse.
				dsp_cmd_wr <= 1'b1;
				repeat (3) @(posedge mclk);
				dsp_cmd_wr <= 1'b0;
				repeat (3) @(posedge mclk);
				dsp_supervisor <= 1'b1;
				repeat (3) @(posedge mclk);
				dsp_cmd_wr <= 1'b1;
				repeat (3) @(posedge mclk);
				dsp_cmd_wr <= 1'b0;
				dsp_supervisor <= 1'b0;
				dsp_cmd_data <= ~PDC_SLEEP_KEY;
				@(posedge mclk);
				dsp_idle <= 1'b1;
			end else if (dsp_idle && wake) begin
				dsp_idle <= 1'b0;
			end
		end
	end
endmodule : dcg_dsp_model

//--- testbench/tb_dcg_sequencer.sv
/* Self-checking bench for the sequencer, with the DSP partner model.
   Assumes a 10 MHz clock and the default settle count. */
`timescale 1ns/1ns
module tb_dcg_sequencer
	import dcg_pkg::*;
;
	logic              mclk, srst, wake, rd_d;
	dcg_bus_t          bus;
	logic [DATA_W-1:0] rdata, dsp_cmd_data;
	logic              dsp_idle, dsp_supervisor, dsp_cmd_wr;
	logic              powerdown_interrupt, processor_root_clock_en, cpu_lowpower;
	logic [GATE_W-1:0] mem_gate;
	logic [DATA_W-1:0] exp_q[$];
	int                mismatches, checks, seed, n;
	dcg_sequencer u_dcg_sequencer (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata),
		.dsp_idle(dsp_idle), .dsp_supervisor(dsp_supervisor), .dsp_cmd_wr(dsp_cmd_wr),
		.dsp_cmd_data(dsp_cmd_data), .powerdown_interrupt(powerdown_interrupt),
		.processor_root_clock_en(processor_root_clock_en),
		.cpu_lowpower(cpu_lowpower), .mem_gate(mem_gate));
	dcg_dsp_model u_dcg_dsp_model (.mclk(mclk), .powerdown_interrupt(powerdown_interrupt),
		.wake(wake), .dsp_idle(dsp_idle), .dsp_supervisor(dsp_supervisor),
		.dsp_cmd_wr(dsp_cmd_wr), .dsp_cmd_data(dsp_cmd_data));
////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// A clock passes after each strobe so no signal is assigned twice in one step.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		@(posedge mclk);
	endtask : rd
	always @(posedge mclk) rd_d <= bus.rd;
	always @(negedge mclk) begin
		if (rd_d === 1'b1 && exp_q.size() > 0)
			check(rdata, exp_q.pop_front());
	end
////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		seed = 32'h44841387;
		bus = '0;
		srst = 1'b1;
		wake = 1'b0;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		check(32'(processor_root_clock_en), 32'h1);
		rd(OFS_MOD_STAT, 32'h3);
		rd(OFS_MOD_CTL, 32'h3);
		rd(OFS_DOM_STAT, 32'h0);
		rd(4'h2, 32'h0);
		wr(OFS_MOD_CTL, {30'h0, ST_DISABLE});
		wr(OFS_DOM_CMD, $random(seed) & 32'hFFFFFFFD);
		rd(OFS_DOM_STAT, 32'h0);
		wr(OFS_DOM_CMD, 32'h2);
		check(32'(powerdown_interrupt), 32'h1);
		rd(OFS_DOM_STAT, 32'h2);
		wr(OFS_DOM_CMD, 32'h2);
		n = 0;
		while (processor_root_clock_en !== 1'b0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		if (n == 100)
			mismatches++;
		rd(OFS_DOM_STAT, 32'h0);
		rd(OFS_MOD_STAT, 32'h2);
		check(32'(powerdown_interrupt), 32'h0);
		check(32'(mem_gate), 32'hFF);
		check(32'(cpu_lowpower), 32'h1);
		wr(OFS_MOD_CTL, {30'h0, ST_ENABLE});
		wr(OFS_DOM_CMD, 32'h2);
		wake <= 1'b1;
		check(32'(processor_root_clock_en), 32'h1);
		rd(OFS_MOD_STAT, 32'h3);
		rd(OFS_DOM_STAT, 32'h0);
		repeat (6) @(posedge mclk);
		check(32'(cpu_lowpower), 32'h0);
		check(32'(mem_gate), 32'h00);
		print_verdict();
	end
endmodule : tb_dcg_sequencer
